// file: verilog/emc_pkg.sv
`default_nettype none

// ============================================================
// Shared constants for the MAC interrupt and PHY management block.
// ============================================================
package emc_pkg;

	// ============================================================
	// Register byte offsets, one aligned word each.
	// ============================================================
	localparam logic [7:0] OFS_STATUS    = 8'h00;
	localparam logic [7:0] OFS_ENABLE    = 8'h04;
	localparam logic [7:0] OFS_DISABLE   = 8'h08;
	localparam logic [7:0] OFS_MASK      = 8'h0c;
	localparam logic [7:0] OFS_MAINT     = 8'h10;
	localparam logic [7:0] OFS_HASH_LOW  = 8'h14;
	localparam logic [7:0] OFS_HASH_HIGH = 8'h18;

	// ============================================================
	// Interrupt status bit positions.
	// ============================================================
	localparam int NUM_FLAGS        = 12;
	localparam int BIT_MGMT_DONE    = 0;
	localparam int BIT_RX_STORED    = 1;
	localparam int BIT_RX_NO_BUF    = 2;
	localparam int BIT_TX_OVERRUN   = 3;
	localparam int BIT_TX_LATE      = 4;
	localparam int BIT_RETRY        = 5;
	localparam int BIT_TX_SLOT_FREE = 6;
	localparam int BIT_TX_SENT      = 7;
	localparam int BIT_TX_ALL_SENT  = 8;
	localparam int BIT_LINK         = 9;
	localparam int BIT_RX_OVERFLOW  = 10;
	localparam int BIT_DMA_ABORT    = 11;

	// ============================================================
	// Reset values.
	// ============================================================
	localparam logic [11:0] RST_STATUS = 12'h000;
	localparam logic [11:0] RST_MASK   = 12'hfff;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	// ============================================================
	// Maintenance frame fields.
	// ============================================================
	localparam int OP_HI           = 29;
	localparam int OP_LO           = 28;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [5:0] LAST_BIT = 6'h1f;
	// Bits before the turnaround field; a read releases the line after.
	localparam logic [5:0] DRIVEN_BITS = 6'h0e;

	// ============================================================
	// Management clock timing.
	// ============================================================
	localparam int CLK_PERIOD_NS = 40;
	localparam int MDC_HALF_NS   = 200;
	localparam logic [2:0] MDC_HALF_CYC =
		3'((MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW  = 3'b010,
		ST_HIGH = 3'b100
	} emc_state_type;

endpackage : emc_pkg

`default_nettype wire

// file: verilog/emc_top.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Management done flag, bit 0, sets when a PHY transfer ends; read clears.
// - Receive complete flag, bit 1, sets when a frame reaches memory.
// - Transmit overrun flag, bit 3, sets on transmit register write while the buffer is still queued (not unqueued).
// - Transmit underrun flag, bit 4, sets when DMA fetches data too late.
// - Retry limit flag, bit 5, sets when transmit retries are exhausted.
// - Slot free flag, bit 6, sets when a buffer may queue; clears when taken.
// - Transmit complete flag, bit 7, sets each time a frame is sent.
// - Transmit idle flag, bit 8, sets once all queued frames are sent.
// - Link change flag, bit 9, sets whenever the link pin changes level.
// - Receive overrun flag, bit 10, sets when receive overrun status sets.
// - Abort flag, bit 11, sets when a DMA transfer aborts.
// - Writing one to the enable register clears the matching mask bit.
// - Writing one to the disable register sets the matching mask bit.
// - Mask reads one for disabled sources, zero for enabled ones.
// - Maintenance write loads the shifter and starts when idle, and is ignored during a transfer; read returns shifter.
// - Each shift drives the line from MSB and loads sampled level into LSB.
// - On completion raise the management event and set the idle indication.
// - Frame holds start, operation, PHY address, register, turnaround, data.
// - Operation 10 means read and 01 means write; others are invalid.
module emc_top
	import emc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_stored_evt,
	input  wire logic        rx_no_buffer_evt,
	input  wire logic        tx_reg_write,
	input  wire logic        tx_buffer_unqueued,
	input  wire logic        tx_fetch_late_evt,
	input  wire logic        retry_exceeded_evt,
	input  wire logic        tx_slot_free_evt,
	input  wire logic        tx_slot_taken,
	input  wire logic        tx_frame_sent_evt,
	input  wire logic        tx_all_sent_evt,
	input  wire logic        rx_overflow_evt,
	input  wire logic        dma_abort_evt,
	input  wire logic        link_pin,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	output logic             mdc,
	output logic             mgmt_idle,
	output logic             irq
);

	// ============================================================
	// Declarations.
	// ============================================================
	logic                 wait_reg;
	logic [31:0]          rdata_reg;
	logic [NUM_FLAGS-1:0] status_reg;
	logic [NUM_FLAGS-1:0] mask_reg;
	logic [31:0]          shift_reg;
	logic [31:0]          hash_low_reg;
	logic [31:0]          hash_high_reg;
	emc_state_type        state_reg;
	logic [2:0]           div_reg;
	logic [5:0]           bit_reg;
	logic                 op_read_reg;
	logic                 mdc_reg;
	logic                 mdio_out_reg;
	logic                 mdio_oe_reg;
	logic                 idle_reg;
	logic                 irq_reg;
	logic                 done_pulse;
	logic                 mdio_s1_reg;
	logic                 mdio_s2_reg;
	logic                 link_s1_reg;
	logic                 link_s2_reg;
	logic                 link_s3_reg;
	logic                 wr_acc;
	logic                 rd_acc;
	logic                 rd_cap;
	logic                 half_end;
	logic                 start_xfer;
	logic [NUM_FLAGS-1:0] set_vec;
	logic [NUM_FLAGS-1:0] clr_vec;
	logic [31:0]          rdata_next;

	// Byte-lane merge of write data into an existing word.
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0]  lanes
	);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				res[8*i +: 8] = new_word[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// ============================================================
	// Bus slave.
	// ============================================================
	// Every access waits exactly one cycle; the answer edge is the one
	// where waitrequest is low, so writes and read clears happen there.
	assign wr_acc = avs_write & ~wait_reg;
	assign rd_acc = avs_read & ~wait_reg;
	assign rd_cap = avs_read & wait_reg;

	// Read data is captured one edge ahead of the answer edge.
	always_comb begin
		rdata_next = RST_WORD;
		unique case (avs_address)
			OFS_STATUS:    rdata_next[NUM_FLAGS-1:0] = status_reg;
			OFS_MASK:      rdata_next[NUM_FLAGS-1:0] = mask_reg;
			OFS_MAINT:     rdata_next = shift_reg;
			OFS_HASH_LOW:  rdata_next = hash_low_reg;
			OFS_HASH_HIGH: rdata_next = hash_high_reg;
			default:       rdata_next = RST_WORD;
		endcase
	end

	// Wait state and read data registers.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_reg  <= 1'b1;
			rdata_reg <= RST_WORD;
		end else begin
			wait_reg <= ~((avs_read | avs_write) & wait_reg);
			if (rd_cap) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;

	// Hash filter, plain storage for the address matcher.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hash_low_reg  <= RST_WORD;
			hash_high_reg <= RST_WORD;
		end else if (wr_acc) begin
			if (avs_address == OFS_HASH_LOW) begin
				hash_low_reg <= merge_bytes(hash_low_reg, avs_writedata,
					avs_byteenable);
			end
			if (avs_address == OFS_HASH_HIGH) begin
				hash_high_reg <= merge_bytes(hash_high_reg, avs_writedata,
					avs_byteenable);
			end
		end
	end

	// ============================================================
	// Interrupt mask.
	// ============================================================
	// A set bit means disabled; ones in enable clear and in disable set.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= RST_MASK;
		end else if (wr_acc && avs_address == OFS_ENABLE) begin
			mask_reg <= mask_reg & ~avs_writedata[NUM_FLAGS-1:0];
		end else if (wr_acc && avs_address == OFS_DISABLE) begin
			mask_reg <= mask_reg | avs_writedata[NUM_FLAGS-1:0];
		end
	end

	// ============================================================
	// Event synchronisers.
	// ============================================================
	// Link and MDIO come from pins, so both pass two flops first.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_s1_reg <= 1'b0;
			link_s2_reg <= 1'b0;
			link_s3_reg <= 1'b0;
			mdio_s1_reg <= 1'b1;
			mdio_s2_reg <= 1'b1;
		end else begin
			link_s1_reg <= link_pin;
			link_s2_reg <= link_s1_reg;
			link_s3_reg <= link_s2_reg;
			mdio_s1_reg <= mdio_in;
			mdio_s2_reg <= mdio_s1_reg;
		end
	end

	// ============================================================
	// Interrupt status.
	// ============================================================
	always_comb begin
		set_vec                   = '0;
		set_vec[BIT_MGMT_DONE]    = done_pulse;
		set_vec[BIT_RX_STORED]    = rx_stored_evt;
		set_vec[BIT_RX_NO_BUF]    = rx_no_buffer_evt;
		set_vec[BIT_TX_OVERRUN]   = tx_reg_write & ~tx_buffer_unqueued;
		set_vec[BIT_TX_LATE]      = tx_fetch_late_evt;
		set_vec[BIT_RETRY]        = retry_exceeded_evt;
		set_vec[BIT_TX_SLOT_FREE] = tx_slot_free_evt;
		set_vec[BIT_TX_SENT]      = tx_frame_sent_evt;
		set_vec[BIT_TX_ALL_SENT]  = tx_all_sent_evt;
		set_vec[BIT_LINK]         = link_s2_reg ^ link_s3_reg;
		set_vec[BIT_RX_OVERFLOW]  = rx_overflow_evt;
		set_vec[BIT_DMA_ABORT]    = dma_abort_evt;
	end

	// Only bits that were actually returned are cleared, so an event
	// landing between capture and answer is not lost unseen.
	always_comb begin
		clr_vec = '0;
		if (rd_acc && avs_address == OFS_STATUS) begin
			clr_vec = rdata_reg[NUM_FLAGS-1:0];
		end
		clr_vec[BIT_TX_SLOT_FREE] = clr_vec[BIT_TX_SLOT_FREE] | tx_slot_taken;
	end

	// Each flag is sticky; a set in the clearing cycle wins.
	for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				status_reg[g] <= RST_STATUS[g];
			end else if (set_vec[g]) begin
				status_reg[g] <= 1'b1;
			end else if (clr_vec[g]) begin
				status_reg[g] <= 1'b0;
			end
		end
	end

	// Interrupt output, one flop behind the flags.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & ~mask_reg);
		end
	end

	assign irq = irq_reg;

	// ============================================================
	// PHY management shifter.
	// ============================================================
	// A write while a transfer runs is ignored to keep the frame whole.
	assign start_xfer = wr_acc && avs_address == OFS_MAINT &&
		state_reg == ST_IDLE;
	assign half_end   = div_reg == MDC_HALF_CYC - 3'h1;
	assign done_pulse = state_reg == ST_HIGH && half_end &&
		bit_reg == LAST_BIT;

	// Sequencer: low half drives, high half ends with the shift.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			div_reg   <= 3'h0;
			bit_reg   <= 6'h00;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_xfer) begin
						state_reg <= ST_LOW;
						div_reg   <= 3'h0;
						bit_reg   <= 6'h00;
					end
				end
				ST_LOW: begin
					div_reg <= half_end ? 3'h0 : div_reg + 3'h1;
					if (half_end) begin
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					div_reg <= half_end ? 3'h0 : div_reg + 3'h1;
					if (half_end) begin
						state_reg <= (bit_reg == LAST_BIT) ? ST_IDLE : ST_LOW;
						bit_reg   <= bit_reg + 6'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Shift data: load on start, shift sampled level in at each bit end.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg   <= RST_WORD;
			op_read_reg <= 1'b0;
		end else if (start_xfer) begin
			shift_reg <= merge_bytes(shift_reg, avs_writedata,
				avs_byteenable);
			// A masked top lane keeps the old operation bits, as the shifter does.
			op_read_reg <= (avs_byteenable[3] ? avs_writedata[OP_HI:OP_LO] :
				shift_reg[OP_HI:OP_LO]) == OP_READ;
		end else if (state_reg == ST_HIGH && half_end) begin
			shift_reg <= {shift_reg[30:0], mdio_s2_reg};
		end
	end

	// Pin drive: a read frame lets go after the register address field.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mdc_reg      <= 1'b0;
			mdio_out_reg <= 1'b1;
			mdio_oe_reg  <= 1'b0;
		end else if (start_xfer) begin
			mdc_reg      <= 1'b0;
			mdio_out_reg <= avs_byteenable[3] ? avs_writedata[31] :
				shift_reg[31];
			mdio_oe_reg  <= 1'b1;
		end else if (state_reg == ST_LOW && half_end) begin
			mdc_reg <= 1'b1;
		end else if (state_reg == ST_HIGH && half_end) begin
			mdc_reg      <= 1'b0;
			mdio_out_reg <= shift_reg[30];
			mdio_oe_reg  <= bit_reg != LAST_BIT &&
				(!op_read_reg || bit_reg + 6'h01 < DRIVEN_BITS);
		end
	end

	// Idle indication for the network status register.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_reg <= 1'b1;
		end else if (start_xfer) begin
			idle_reg <= 1'b0;
		end else if (done_pulse) begin
			idle_reg <= 1'b1;
		end
	end

	assign mdc       = mdc_reg;
	assign mdio_out  = mdio_out_reg;
	assign mdio_oe   = mdio_oe_reg;
	assign mgmt_idle = idle_reg;

	// ============================================================
	// Assertions.
	// ============================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_start;
		start_xfer;
	endsequence

	sequence s_bit_end;
		state_reg == ST_HIGH && half_end;
	endsequence

	a_done_flag: assert property (done_pulse |=> status_reg[BIT_MGMT_DONE])
		else $error("done flag not set");
	a_rx_flag: assert property (rx_stored_evt |=> status_reg[BIT_RX_STORED])
		else $error("rx flag not set");
	a_ovr_flag: assert property (tx_reg_write && !tx_buffer_unqueued
		|=> status_reg[BIT_TX_OVERRUN])
		else $error("overrun flag not set");
	a_late_flag: assert property (tx_fetch_late_evt
		|=> status_reg[BIT_TX_LATE])
		else $error("underrun flag not set");
	a_retry_flag: assert property (retry_exceeded_evt
		|=> status_reg[BIT_RETRY])
		else $error("retry flag not set");
	a_slot_taken: assert property (tx_slot_taken && !tx_slot_free_evt
		|=> !status_reg[BIT_TX_SLOT_FREE])
		else $error("slot flag not cleared");
	a_sent_flag: assert property (tx_frame_sent_evt
		|=> status_reg[BIT_TX_SENT])
		else $error("sent flag not set");
	a_all_sent: assert property (tx_all_sent_evt
		|=> status_reg[BIT_TX_ALL_SENT])
		else $error("idle flag not set");
	a_link_flag: assert property ($changed(link_s2_reg)
		|=> status_reg[BIT_LINK])
		else $error("link flag not set");
	a_rx_overflow_flag_flag: assert property (rx_overflow_evt
		|=> status_reg[BIT_RX_OVERFLOW])
		else $error("rx overrun flag not set");
	a_abort_flag: assert property (dma_abort_evt
		|=> status_reg[BIT_DMA_ABORT])
		else $error("abort flag not set");
	a_read_clear: assert property (rd_acc && avs_address == OFS_STATUS
		&& set_vec == '0 && !tx_slot_taken
		|=> (status_reg & $past(rdata_reg[NUM_FLAGS-1:0])) == '0)
		else $error("status read did not clear");
	a_enable_write: assert property (wr_acc && avs_address == OFS_ENABLE
		|=> (mask_reg & $past(avs_writedata[NUM_FLAGS-1:0])) == '0)
		else $error("enable write left mask set");
	a_disable_write: assert property (wr_acc && avs_address == OFS_DISABLE
		|=> (~mask_reg & $past(avs_writedata[NUM_FLAGS-1:0])) == '0)
		else $error("disable write left mask clear");
	a_mask_read: assert property (rd_cap && avs_address == OFS_MASK
		|=> avs_readdata == {20'h00000, $past(mask_reg)})
		else $error("mask read wrong");
	a_start_load: assert property (s_start
		|=> !mgmt_idle && state_reg == ST_LOW && mdio_oe)
		else $error("transfer did not start");
	a_shift_in: assert property (s_bit_end
		|=> shift_reg[0] == $past(mdio_s2_reg)
		&& shift_reg[31:1] == $past(shift_reg[30:0]))
		else $error("shift wrong");
	a_done_idle: assert property (done_pulse
		|=> mgmt_idle && status_reg[BIT_MGMT_DONE] && !mdio_oe)
		else $error("completion not reported");
	a_irq_out: assert property ((status_reg & ~mask_reg) != '0
		|=> irq)
		else $error("irq not raised");
	a_irq_low: assert property ((status_reg & ~mask_reg) == '0 |=> !irq)
		else $error("irq not dropped");

endmodule : emc_top

`default_nettype wire

// file: test/emc_phy_model.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Behavioural PHY on the management link.
// ============================================================
module emc_phy_model (
	input  wire logic        rst_b,
	input  wire logic        mdc,
	input  wire logic        mdio,
	input  wire logic [15:0] rd_word,
	output logic             phy_out,
	output logic             phy_oe,
	output logic [31:0]      last_frame
);

	logic [31:0] rx_reg;
	// Known from the start: no reset edge reaches this process at time zero.
	logic [4:0]  cnt_reg = 5'h00;
	logic [1:0]  op_reg;

	// Sample the line on each rising management clock, first bit on top.
	always @(posedge mdc or negedge rst_b) begin
		if (!rst_b) begin
			rx_reg     <= 32'h0000_0000;
			cnt_reg    <= 5'h00;
			last_frame <= 32'h0000_0000;
		end else begin
			rx_reg  <= {rx_reg[30:0], mdio};
			cnt_reg <= cnt_reg + 5'h01;
			if (cnt_reg == 5'h1f) begin
				last_frame <= {rx_reg[30:0], mdio};
			end
		end
	end

	// Decode the operation and answer reads after the turnaround.
	// Only the second turnaround bit is driven; the first is left to the
	// pull-up so that a device driving too long shows up as a clash.
	always @(negedge mdc or negedge rst_b) begin
		if (!rst_b) begin
			op_reg  <= 2'h0;
			phy_oe  <= 1'b0;
			phy_out <= 1'b1;
		end else begin
			if (cnt_reg == 5'h04) begin
				op_reg <= rx_reg[1:0];
			end
			if (op_reg == 2'h2 && cnt_reg >= 5'h0f) begin
				phy_oe  <= 1'b1;
				phy_out <= (cnt_reg == 5'h0f) ? 1'b0 : rd_word[4'(31 - cnt_reg)];
			end else begin
				phy_oe  <= 1'b0;
				phy_out <= 1'b1;
			end
		end
	end

endmodule : emc_phy_model

`default_nettype wire

// file: test/emc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Self-checking bench for the interrupt and PHY management block.
// ============================================================
module emc_top_tb import emc_pkg::*;;

	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [11:0] ev = 12'h000;
	logic        tx_buffer_unqueued = 1'b0;
	logic        link_pin = 1'b0;
	logic        mdio_out;
	logic        mdio_oe;
	logic        mdc;
	logic        mgmt_idle;
	logic        irq;
	logic        phy_out;
	logic        phy_oe;
	logic [31:0] last_frame;
	logic [31:0] q;
	logic [15:0] rd_word = 16'hc35a;
	wire logic   mdio_line;
	int          failures = 0;
	int          checks = 0;
	int          cyc = 0;
	int          b;
	int          rises = 0;

	// The line has a pull-up, so it reads high when nobody drives it.
	assign mdio_line = (mdio_oe ? mdio_out : 1'b1) & (phy_oe ? phy_out : 1'b1);

	always #20 core_clk = ~core_clk;

	// Event bit 0 carries the slot-taken pulse; bit 9 is unused, as link_pin drives the link flag; the others map to flags.
	emc_top u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_stored_evt(ev[1]),
		.rx_no_buffer_evt(ev[2]), .tx_reg_write(ev[3]),
		.tx_buffer_unqueued(tx_buffer_unqueued), .tx_fetch_late_evt(ev[4]),
		.retry_exceeded_evt(ev[5]), .tx_slot_free_evt(ev[6]),
		.tx_slot_taken(ev[0]), .tx_frame_sent_evt(ev[7]),
		.tx_all_sent_evt(ev[8]), .rx_overflow_evt(ev[10]),
		.dma_abort_evt(ev[11]), .link_pin(link_pin), .mdio_in(mdio_line),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
		.mgmt_idle(mgmt_idle), .irq(irq));

	emc_phy_model u_phy (.rst_b(rst_b), .mdc(mdc), .mdio(mdio_line),
		.rd_word(rd_word), .phy_out(phy_out), .phy_oe(phy_oe),
		.last_frame(last_frame));

	// ============================================================
	// Shared tasks.
	// ============================================================
	task automatic summarize;
		if (failures == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One bus cycle; the request is held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		// Only the bench timeout may end this wait.
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		chk(q, e);
	endtask : rd

	task automatic ev_go(input int k);
		@(posedge core_clk);
		if (k == 9) link_pin <= ~link_pin;
		else ev[k] <= 1'b1;
		@(posedge core_clk);
		ev <= 12'h000;
	endtask : ev_go

	// Runs one management frame, with a write attempt while it is busy.
	task automatic frame(input logic [31:0] w, input logic [31:0] e);
		wr(OFS_MAINT, w);
		@(posedge core_clk);
		chk({31'h0, mgmt_idle}, 32'h0);
		rises = 0;
		wr(OFS_MAINT, 32'h0000_0000);
		while (mgmt_idle !== 1'b1) begin
			@(posedge core_clk);
		end
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		chk(32'(rises), 32'd32);
		rd(OFS_MAINT, e);
		chk(last_frame, e);
		rd(OFS_STATUS, 32'h001);
	endtask : frame

	always @(posedge mdc) rises++;

	// Cut a hang short well past the expected run length.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 4000) begin
			failures++;
			summarize();
		end
	end

	// ============================================================
	// Main sequence.
	// ============================================================
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(OFS_STATUS, 32'h0);
		rd(OFS_MASK, 32'hfff);
		rd(OFS_ENABLE, 32'h0);
		rd(OFS_MAINT, 32'h0);
		rd(8'h1c, 32'h0);
		wr(OFS_HASH_LOW, 32'hdead_beef);
		wr(OFS_HASH_HIGH, 32'h1234_5678);
		bus(1'b1, OFS_HASH_HIGH, 32'haaaa_bbbb, 4'h3);
		rd(OFS_HASH_LOW, 32'hdead_beef);
		rd(OFS_HASH_HIGH, 32'h1234_bbbb);
		wr(OFS_MASK, 32'h0);
		rd(OFS_MASK, 32'hfff);
		wr(OFS_ENABLE, 32'h0a5);
		rd(OFS_MASK, 32'hf5a);
		wr(OFS_ENABLE, 32'h0);
		wr(OFS_DISABLE, 32'h005);
		rd(OFS_MASK, 32'hf5f);
		wr(OFS_ENABLE, 32'hfff);
		// Sources 1 to 11 in turn: flag, output, then clear on read.
		for (b = 1; b < 12; b++) begin
			ev_go(b);
			repeat (5) @(posedge core_clk);
			chk({31'h0, irq}, 32'h1);
			rd(OFS_STATUS, 32'h1 << b);
			rd(OFS_STATUS, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		ev_go(6);
		ev_go(0);
		rd(OFS_STATUS, 32'h0);
		tx_buffer_unqueued <= 1'b1;
		ev_go(3);
		rd(OFS_STATUS, 32'h0);
		tx_buffer_unqueued <= 1'b0;
		wr(OFS_DISABLE, 32'h080);
		ev_go(7);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_STATUS, 32'h080);
		wr(OFS_ENABLE, 32'h080);
		// Write frame: start 01, operation 01, turnaround 10.
		frame(32'h5086_a5c3, 32'h5086_a5c3);
		// Read frame: the data field returns the PHY's answer.
		frame(32'h6086_0000, 32'h6086_c35a);
		summarize();
	end

endmodule : emc_top_tb

`default_nettype wire
